// ### spcd_pkg.sv
package spcd_pkg;

    // ==========================================================
    // Instruction first bytes
    localparam logic [7:0] CMD_PROG        = 8'hAC;
    localparam logic [7:0] CMD_POLL        = 8'hF0;
    localparam logic [7:0] CMD_LOAD_EXT    = 8'h4D;
    localparam logic [7:0] CMD_LOAD_HI     = 8'h48;
    localparam logic [7:0] CMD_LOAD_LO     = 8'h40;
    localparam logic [7:0] CMD_LOAD_EE     = 8'hC1;
    localparam logic [7:0] CMD_RD_FL_HI    = 8'h28;
    localparam logic [7:0] CMD_RD_FL_LO    = 8'h20;
    localparam logic [7:0] CMD_RD_EE       = 8'hA0;
    localparam logic [7:0] CMD_RD_LOCK_FH  = 8'h58;
    localparam logic [7:0] CMD_RD_FUSE     = 8'h50;
    localparam logic [7:0] CMD_RD_CAL      = 8'h38;
    localparam logic [7:0] CMD_RD_SIG      = 8'h30;
    localparam logic [7:0] CMD_WR_FL_PAGE  = 8'h4C;
    localparam logic [7:0] CMD_WR_EE       = 8'hC0;
    localparam logic [7:0] CMD_WR_EE_PAGE  = 8'hC2;

    // ==========================================================
    // Second-byte selectors
    localparam logic [7:0] SEL_ENABLE      = 8'h53;
    localparam logic [7:0] SEL_ERASE       = 8'h80;
    localparam logic [7:0] SEL_WR_LOCK     = 8'hE0;
    localparam logic [7:0] SEL_WR_FUSE_LO  = 8'hA0;
    localparam logic [7:0] SEL_WR_FUSE_HI  = 8'hA8;
    localparam logic [7:0] SEL_WR_FUSE_EXT = 8'hA4;
    localparam logic [7:0] SEL_FUSE_UPPER  = 8'h08;

    // ==========================================================
    // Field positions, widths and reset values
    localparam int         POLL_BIT        = 0;
    localparam int         MEM_ADDR_W      = 24;
    localparam logic [7:0] TX_RST          = 8'h00;
    localparam logic [7:0] EXT_ADDR_RST    = 8'h00;
    localparam logic [7:0] BYTE_RST        = 8'h00;

    // ==========================================================
    // Session and back-end operation codes
    typedef enum logic {SES_LOCKED, SES_ENABLED} spcd_ses_e;

    typedef enum logic [4:0] {
        OP_NONE, OP_CHIP_ERASE, OP_FL_LOAD_LO, OP_FL_LOAD_HI,
        OP_FL_WRITE_PAGE, OP_FL_READ_LO, OP_FL_READ_HI, OP_EE_LOAD,
        OP_EE_WRITE_PAGE, OP_EE_WRITE, OP_EE_READ, OP_LOCK_RD,
        OP_FUSE_LO_RD, OP_FUSE_HI_RD, OP_FUSE_EXT_RD, OP_CAL_RD,
        OP_SIG_RD, OP_LOCK_WR, OP_FUSE_LO_WR, OP_FUSE_HI_WR,
        OP_FUSE_EXT_WR
    } spcd_op_e;

endpackage : spcd_pkg

// ### spcd_serial_port.sv
module spcd_serial_port (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sck_pin,
    input  wire logic       mosi_pin,
    input  wire logic       prog_rst_n_pin,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic            rst_pin_lvl,
    output logic            byte_done,
    output logic [1:0]      byte_idx,
    output logic [7:0]      rx_byte
);
    import spcd_pkg::*;

    // ==========================================================
    // Pin synchronisers: 0 = clock, 1 = data in, 2 = reset pin
    logic [2:0][2:0] sync_reg, sync_next;
    logic [2:0]      lvl_reg, lvl_next;
    logic [4:0]      bit_cnt_reg, bit_cnt_next;
    logic [7:0]      rx_sh_reg, rx_sh_next;
    logic [7:0]      tx_sh_reg, tx_sh_next;
    logic [7:0]      rx_reg, rx_next;
    logic [1:0]      idx_reg, idx_next;
    logic            done_reg, done_next;
    logic            miso_reg, miso_next;
    logic            rise;
    logic            fall;
    logic [2:0]      pins;

    assign pins = {prog_rst_n_pin, mosi_pin, sck_pin};

    // Level accepted only when stages two and three agree
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            sync_next[i] = {sync_reg[i][1:0], pins[i]};
            lvl_next[i]  = (sync_reg[i][1] == sync_reg[i][2]) ?
                           sync_reg[i][2] : lvl_reg[i];
        end
    end

    assign rise = lvl_next[0] & ~lvl_reg[0];
    assign fall = ~lvl_next[0] & lvl_reg[0];

    // Framing and shifting; reset pin high drops any partial frame
    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        rx_sh_next   = rx_sh_reg;
        tx_sh_next   = tx_sh_reg;
        rx_next      = rx_reg;
        idx_next     = idx_reg;
        done_next    = 1'b0;
        miso_next    = miso_reg;
        if (lvl_reg[2]) begin
            bit_cnt_next = 5'h00;
            miso_next    = 1'b0;
        end else if (rise) begin
            rx_sh_next   = {rx_sh_reg[6:0], lvl_reg[1]};
            bit_cnt_next = bit_cnt_reg + 5'h01;
            if (bit_cnt_reg[2:0] == 3'h7) begin
                done_next = 1'b1;
                rx_next   = {rx_sh_reg[6:0], lvl_reg[1]};
                idx_next  = bit_cnt_reg[4:3];
            end
        end else if (fall) begin
            // Byte boundary: load the next answer, MSB goes out first
            if (bit_cnt_reg[2:0] == 3'h0) begin
                miso_next  = tx_byte[7];
                tx_sh_next = {tx_byte[6:0], 1'b0};
            end else begin
                miso_next  = tx_sh_reg[7];
                tx_sh_next = {tx_sh_reg[6:0], 1'b0};
            end
        end
    end

    // Registers; reset pin level starts high so no session is assumed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_reg    <= {3'h7, 3'h0, 3'h0};   // Idle levels: no false edge
            lvl_reg     <= 3'h4;
            bit_cnt_reg <= 5'h00;
            rx_sh_reg   <= BYTE_RST;
            tx_sh_reg   <= BYTE_RST;
            rx_reg      <= BYTE_RST;
            idx_reg     <= 2'h0;
            done_reg    <= 1'b0;
            miso_reg    <= 1'b0;
        end else begin
            sync_reg    <= sync_next;
            lvl_reg     <= lvl_next;
            bit_cnt_reg <= bit_cnt_next;
            rx_sh_reg   <= rx_sh_next;
            tx_sh_reg   <= tx_sh_next;
            rx_reg      <= rx_next;
            idx_reg     <= idx_next;
            done_reg    <= done_next;
            miso_reg    <= miso_next;
        end
    end

    assign miso        = miso_reg;
    assign rst_pin_lvl = lvl_reg[2];
    assign byte_done   = done_reg;
    assign byte_idx    = idx_reg;
    assign rx_byte     = rx_reg;

    // ==========================================================
    // Checks
    AST_MISO_ON_FALL: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(miso_reg) |-> $past(fall) || $past(lvl_reg[2]))
        else $error("output bit changed without a falling clock edge");

    AST_RX_MSB_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
        rise && !lvl_reg[2] && bit_cnt_reg[2:0] == 3'h7
        |=> done_reg && rx_reg[0] == $past(lvl_reg[1])
            && rx_reg[7] == $past(rx_sh_reg[6]))
        else $error("received byte not assembled MSB first");

endmodule : spcd_serial_port

// ### spcd_decoder.sv
module spcd_decoder (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           sck,
    input  wire logic                           mosi,
    input  wire logic                           prog_rst_n,
    input  wire logic                           op_pending_flag,
    input  wire logic [7:0]                     mem_rdata,
    output logic                                miso,
    output logic                                prog_enabled,
    output logic                                mem_strobe,
    output spcd_pkg::spcd_op_e                  mem_op,
    output logic [spcd_pkg::MEM_ADDR_W-1:0]     mem_addr,
    output logic [7:0]                          mem_wdata
);
    import spcd_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [MEM_ADDR_W-1:0] fl_addr(
        input logic [7:0] ext, input logic [7:0] hi, input logic [7:0] lo);
        fl_addr = {ext, hi, lo};
    endfunction : fl_addr

    function automatic logic [MEM_ADDR_W-1:0] ee_addr(
        input logic [7:0] hi, input logic [7:0] lo);
        ee_addr = {14'h0, hi[1:0], lo};
    endfunction : ee_addr

    function automatic logic is_read(input spcd_op_e op);
        is_read = (op inside {OP_FL_READ_LO, OP_FL_READ_HI, OP_EE_READ,
                              OP_LOCK_RD, OP_FUSE_LO_RD, OP_FUSE_HI_RD,
                              OP_FUSE_EXT_RD, OP_CAL_RD, OP_SIG_RD});
    endfunction : is_read

    // Second byte of an AC frame selects erase or a fuse or lock write
    function automatic spcd_op_e prog_op(input logic [7:0] sel);
        case (sel)
            SEL_ERASE:       prog_op = OP_CHIP_ERASE;
            SEL_WR_LOCK:     prog_op = OP_LOCK_WR;
            SEL_WR_FUSE_LO:  prog_op = OP_FUSE_LO_WR;
            SEL_WR_FUSE_HI:  prog_op = OP_FUSE_HI_WR;
            SEL_WR_FUSE_EXT: prog_op = OP_FUSE_EXT_WR;
            default:         prog_op = OP_NONE;
        endcase
    endfunction : prog_op

    // ==========================================================
    // Serial front end
    logic       rst_lvl;
    logic       byte_done;
    logic [1:0] byte_idx;
    logic [7:0] rx_byte;
    logic [7:0] tx_reg, tx_next;

    spcd_serial_port u_port (
        .clk            (clk),
        .rst_n          (rst_n),
        .sck_pin        (sck),
        .mosi_pin       (mosi),
        .prog_rst_n_pin (prog_rst_n),
        .tx_byte        (tx_reg),
        .miso           (miso),
        .rst_pin_lvl    (rst_lvl),
        .byte_done      (byte_done),
        .byte_idx       (byte_idx),
        .rx_byte        (rx_byte)
    );

    // ==========================================================
    // Decoder state
    spcd_ses_e             ses_reg, ses_next;
    spcd_op_e              op_reg, op_next, cmd_op;
    logic [7:0]            b1_reg, b1_next, b2_reg, b2_next;
    logic [7:0]            b3_reg, b3_next, ext_reg, ext_next;
    logic [7:0]            wd_reg, wd_next;
    logic [MEM_ADDR_W-1:0] addr_reg, addr_next;
    logic                  stb_reg, stb_next;
    logic                  enabled;

    assign enabled = (ses_reg == SES_ENABLED);

    // Reads issue after byte three so data is ready for byte four;
    // writes wait for byte four so a cut frame never writes
    always_comb begin
        ses_next  = ses_reg;
        b1_next   = b1_reg;
        b2_next   = b2_reg;
        b3_next   = b3_reg;
        ext_next  = ext_reg;
        tx_next   = tx_reg;
        op_next   = op_reg;
        addr_next = addr_reg;
        wd_next   = wd_reg;
        stb_next  = 1'b0;
        cmd_op    = OP_NONE;
        if (stb_reg && is_read(op_reg)) begin
            tx_next = mem_rdata;
        end
        if (rst_lvl) begin
            ses_next = SES_LOCKED;
            tx_next  = TX_RST;
        end else if (byte_done) begin
            case (byte_idx)
                2'd0: begin
                    b1_next = rx_byte;
                    tx_next = TX_RST;
                end
                2'd1: begin
                    b2_next = rx_byte;
                    tx_next = rx_byte;
                end
                2'd2: begin
                    b3_next = rx_byte;
                    tx_next = TX_RST;
                    if (enabled) begin
                        case (b1_reg)
                            CMD_POLL:
                                tx_next[POLL_BIT] = op_pending_flag;
                            CMD_RD_FL_HI: begin
                                cmd_op    = OP_FL_READ_HI;
                                addr_next = fl_addr(ext_reg, b2_reg, rx_byte);
                            end
                            CMD_RD_FL_LO: begin
                                cmd_op    = OP_FL_READ_LO;
                                addr_next = fl_addr(ext_reg, b2_reg, rx_byte);
                            end
                            CMD_RD_EE: begin
                                cmd_op    = OP_EE_READ;
                                addr_next = ee_addr(b2_reg, rx_byte);
                            end
                            CMD_RD_LOCK_FH: cmd_op = (b2_reg == SEL_FUSE_UPPER)
                                ? OP_FUSE_HI_RD : OP_LOCK_RD;
                            CMD_RD_FUSE: cmd_op = (b2_reg == SEL_FUSE_UPPER)
                                ? OP_FUSE_EXT_RD : OP_FUSE_LO_RD;
                            CMD_RD_CAL: cmd_op = OP_CAL_RD;
                            CMD_RD_SIG: begin
                                cmd_op    = OP_SIG_RD;
                                addr_next = ee_addr(BYTE_RST,
                                                    {6'h00, rx_byte[1:0]});
                            end
                            default: cmd_op = OP_NONE;
                        endcase
                    end
                end
                default: begin
                    tx_next = TX_RST;
                    wd_next = rx_byte;
                    if (b1_reg == CMD_PROG && b2_reg == SEL_ENABLE) begin
                        ses_next = SES_ENABLED;
                    end else if (enabled) begin
                        case (b1_reg)
                            CMD_PROG: cmd_op = prog_op(b2_reg);
                            CMD_LOAD_EXT: ext_next = b3_reg;
                            CMD_LOAD_HI, CMD_LOAD_LO: begin
                                cmd_op = (b1_reg == CMD_LOAD_HI)
                                    ? OP_FL_LOAD_HI : OP_FL_LOAD_LO;
                                addr_next = ee_addr(BYTE_RST, b3_reg);
                            end
                            CMD_LOAD_EE: begin
                                cmd_op    = OP_EE_LOAD;
                                addr_next = ee_addr(BYTE_RST,
                                                    {6'h00, b3_reg[1:0]});
                            end
                            CMD_WR_FL_PAGE: begin
                                cmd_op    = OP_FL_WRITE_PAGE;
                                addr_next = fl_addr(ext_reg, b2_reg, b3_reg);
                            end
                            CMD_WR_EE_PAGE: begin
                                cmd_op    = OP_EE_WRITE_PAGE;
                                addr_next = ee_addr(b2_reg,
                                                    {b3_reg[7:2], 2'b00});
                            end
                            CMD_WR_EE: begin
                                cmd_op    = OP_EE_WRITE;
                                addr_next = ee_addr(b2_reg, b3_reg);
                            end
                            default: cmd_op = OP_NONE;
                        endcase
                    end
                end
            endcase
        end
        if (cmd_op != OP_NONE) begin
            stb_next = 1'b1;
            op_next  = cmd_op;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ses_reg  <= SES_LOCKED;
            b1_reg   <= BYTE_RST;
            b2_reg   <= BYTE_RST;
            b3_reg   <= BYTE_RST;
            ext_reg  <= EXT_ADDR_RST;
            tx_reg   <= TX_RST;
            op_reg   <= OP_NONE;
            addr_reg <= '0;
            wd_reg   <= BYTE_RST;
            stb_reg  <= 1'b0;
        end else begin
            ses_reg  <= ses_next;
            b1_reg   <= b1_next;
            b2_reg   <= b2_next;
            b3_reg   <= b3_next;
            ext_reg  <= ext_next;
            tx_reg   <= tx_next;
            op_reg   <= op_next;
            addr_reg <= addr_next;
            wd_reg   <= wd_next;
            stb_reg  <= stb_next;
        end
    end

    assign prog_enabled = enabled;
    assign mem_strobe   = stb_reg;
    assign mem_op       = op_reg;
    assign mem_addr     = addr_reg;
    assign mem_wdata    = wd_reg;

    // ==========================================================
    // Checks
    logic exec4;
    logic step3;
    assign exec4 = byte_done && byte_idx == 2'd3 && !rst_lvl;
    assign step3 = byte_done && byte_idx == 2'd2 && !rst_lvl && enabled;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_ENABLE: assert property (exec4 && b1_reg == CMD_PROG
        && b2_reg == SEL_ENABLE |=> ses_reg == SES_ENABLED)
        else $error("programming enable not accepted");
    AST_LOCKED_QUIET: assert property (ses_reg == SES_LOCKED
        |=> !stb_reg)
        else $error("operation issued before programming enable");
    AST_POLL: assert property (step3 && b1_reg == CMD_POLL
        |=> tx_reg[POLL_BIT] == $past(op_pending_flag))
        else $error("poll status bit wrong");
    AST_EXT_ADDR: assert property (exec4 && enabled
        && b1_reg == CMD_LOAD_EXT |=> ext_reg == $past(b3_reg))
        else $error("extended address not stored");
    AST_LOAD_HI: assert property (exec4 && enabled && b1_reg == CMD_LOAD_HI
        |=> stb_reg && op_reg == OP_FL_LOAD_HI
            && wd_reg == $past(rx_byte)
            && addr_reg[7:0] == $past(b3_reg))
        else $error("page high byte load wrong");
    AST_EE_LOAD: assert property (exec4 && enabled && b1_reg == CMD_LOAD_EE
        |=> op_reg == OP_EE_LOAD && addr_reg[1:0] == $past(b3_reg[1:0])
            && addr_reg[MEM_ADDR_W-1:2] == '0)
        else $error("eeprom page position wrong");
    AST_READ_DATA: assert property (step3 && b1_reg == CMD_RD_EE
        |=> stb_reg && op_reg == OP_EE_READ
        ##1 tx_reg == $past(mem_rdata))
        else $error("read data not returned in byte four");
    AST_EE_PAGE: assert property (exec4 && enabled
        && b1_reg == CMD_WR_EE_PAGE
        |=> stb_reg && addr_reg[1:0] == 2'b00)
        else $error("eeprom page commit address wrong");
    AST_FL_PAGE: assert property (exec4 && enabled
        && b1_reg == CMD_WR_FL_PAGE
        |=> stb_reg && addr_reg == {$past(ext_reg), $past(b2_reg),
                                     $past(b3_reg)})
        else $error("flash page commit address wrong");
    AST_ECHO: assert property (byte_done && byte_idx == 2'd1 && !rst_lvl
        |=> tx_reg == $past(rx_byte))
        else $error("second byte not echoed");

endmodule : spcd_decoder

// ### spcd_prog_model.sv
// ==========================================================
// Programmer model: drives the serial link one frame at a time
module spcd_prog_model (
    input  wire logic clk,
    input  wire logic miso,
    output logic      sck,
    output logic      mosi
);
    timeunit 1ns;
    timeprecision 1ps;

    // Link idles with the clock low so a session can start cleanly
    initial begin
        sck  = 1'b0;
        mosi = 1'b0;
    end

    // Thirty-two bits per frame, four clk per phase (16 ns each)
    task automatic xfer(input logic [31:0] f, output logic [31:0] r);
        for (int i = 31; i >= 0; i--) begin
            mosi <= f[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            // Read mid-high: the answer only moves after a fall
            repeat (3) @(posedge clk);
            r[i] = miso;
            @(posedge clk);
            sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        mosi <= ~mosi;                        // Stale data is not kept
    endtask : xfer
endmodule : spcd_prog_model

// ### tb.sv
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end

module tb;
    import spcd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    logic                  clk, rst_n, prog_rst_n, op_pending_flag;
    logic                  sck, mosi, miso, prog_enabled, mem_strobe;
    logic [7:0]            mem_rdata, mem_wdata, lfsr, ext, pos;
    logic [MEM_ADDR_W-1:0] mem_addr;
    logic [31:0]           f, r;
    spcd_op_e              mem_op;
    int                    err_total, total_checks, n_strobe;
    logic [15:0]           ops [22] = '{16'hAC80, 16'h4D00, 16'h4000,
        16'h4800, 16'hC100, 16'h4C00, 16'hC000, 16'hC200, 16'hACE0,
        16'hACA0, 16'hACA8, 16'hACA4, 16'h2800, 16'h2000, 16'hA000,
        16'h5800, 16'h5000, 16'h5808, 16'h5008, 16'h3800, 16'h3000,
        16'hF000};
    spcd_op_e              eop [22] = '{OP_CHIP_ERASE, OP_NONE,
        OP_FL_LOAD_LO, OP_FL_LOAD_HI, OP_EE_LOAD, OP_FL_WRITE_PAGE,
        OP_EE_WRITE, OP_EE_WRITE_PAGE, OP_LOCK_WR, OP_FUSE_LO_WR,
        OP_FUSE_HI_WR, OP_FUSE_EXT_WR, OP_FL_READ_HI, OP_FL_READ_LO,
        OP_EE_READ, OP_LOCK_RD, OP_FUSE_LO_RD, OP_FUSE_HI_RD,
        OP_FUSE_EXT_RD, OP_CAL_RD, OP_SIG_RD, OP_NONE};

    spcd_decoder DUT (.clk(clk), .rst_n(rst_n), .sck(sck), .mosi(mosi),
        .prog_rst_n(prog_rst_n), .op_pending_flag(op_pending_flag),
        .mem_rdata(mem_rdata), .miso(miso), .prog_enabled(prog_enabled),
        .mem_strobe(mem_strobe), .mem_op(mem_op), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata));
    spcd_prog_model prog (.clk(clk), .miso(miso), .sck(sck), .mosi(mosi));

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Count back-end strobes to catch missing or doubled operations
    always @(posedge clk) begin
        if (mem_strobe === 1'b1) n_strobe <= n_strobe + 1;
    end

    // ==========================================================
    // Expectations
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nxt

    function automatic logic [23:0] exp_addr(input logic [31:0] g);
        case (g[31:24])
            CMD_RD_FL_HI, CMD_RD_FL_LO,
            CMD_WR_FL_PAGE:           return {ext, g[23:8]};
            CMD_RD_EE, CMD_WR_EE,
            CMD_WR_EE_PAGE:           return {14'h0, g[17:8]};
            CMD_LOAD_HI, CMD_LOAD_LO: return {16'h0, g[15:8]};
            default:                  return {22'h0, g[9:8]};
        endcase
    endfunction : exp_addr

    // One frame, then compare what the back end and the link showed
    task automatic run(input logic [31:0] g, input spcd_op_e op);
        int s0;
        s0 = n_strobe;
        prog.xfer(g, r);
        repeat (8) @(posedge clk);
        `CHK(n_strobe - s0, int'(op != OP_NONE))
        if (prog_enabled === 1'b1) `CHK(r[15:8], g[23:16])
        if (op inside {[OP_LOCK_RD:OP_SIG_RD], OP_FL_READ_LO, OP_FL_READ_HI,
            OP_EE_READ}) `CHK(r[7:0], mem_rdata)
        else if (op != OP_NONE) `CHK(mem_wdata, g[7:0])
        if (op != OP_NONE) `CHK(mem_op, op)
        if (op != OP_NONE && g[31:24] inside {CMD_RD_FL_HI, CMD_RD_FL_LO,
            CMD_WR_FL_PAGE, CMD_RD_EE, CMD_WR_EE, CMD_WR_EE_PAGE, CMD_LOAD_HI,
            CMD_LOAD_LO, CMD_LOAD_EE, CMD_RD_SIG})
            `CHK(mem_addr, exp_addr(g))
    endtask : run

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // Hang guard, well past the longest expected run
    initial begin
        #200000;
        err_total++;
        tally_and_finish;
    end

    // ==========================================================
    // Main sequence
    initial begin
        {rst_n, op_pending_flag, mem_rdata, ext} = '0;
        {err_total, total_checks, n_strobe} = '0;
        prog_rst_n = 1'b1;
        lfsr = 8'h1C;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        prog_rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        run({CMD_RD_EE, 24'h000100}, OP_NONE); // Refused while locked
        `CHK(r[23:0], 24'h0)
        run({CMD_PROG, SEL_ENABLE, 16'h0}, OP_NONE);
        `CHK(prog_enabled, 1'b1)
        // Low byte load goes before high byte load in the table order
        for (int p = 0; p < 3; p++) for (int k = 0; k < 22; k++) begin
            lfsr = nxt(lfsr);
            f = {ops[k], lfsr, nxt(lfsr)};
            lfsr = nxt(lfsr);
            // Top of every address field; selector bytes stay as listed
            if (p == 2) f[15:8] = 8'hFF;
            if (p == 2 && ops[k][15:8] inside {CMD_RD_FL_HI, CMD_RD_FL_LO,
                CMD_WR_FL_PAGE, CMD_RD_EE, CMD_WR_EE, CMD_WR_EE_PAGE})
                f[23:16] = 8'hFF;
            if (ops[k][15:8] inside {CMD_RD_EE, CMD_WR_EE, CMD_WR_EE_PAGE})
                f[23:18] = 6'h0;
            if (ops[k][15:8] inside {CMD_LOAD_EE, CMD_RD_SIG})
                f[15:10] = 6'h0;
            if (ops[k][15:8] == CMD_WR_EE_PAGE) f[9:8] = 2'h0;
            if (ops[k][15:8] == CMD_LOAD_EXT) ext = f[15:8];
            // High byte goes to the position whose low byte was just loaded
            if (ops[k][15:8] == CMD_LOAD_LO) pos = f[15:8];
            if (ops[k][15:8] == CMD_LOAD_HI) f[15:8] = pos;
            mem_rdata <= nxt(lfsr);
            op_pending_flag <= lfsr[0];
            @(posedge clk);
            run(f, eop[k]);
            if (ops[k] == 16'hF000) begin
                `CHK(r[7:0], {7'h00, op_pending_flag})
                // Poll once more, with the flag cleared, if the operation was reported busy
                if (r[0] === 1'b1) begin
                    op_pending_flag <= 1'b0;
                    @(posedge clk);
                    run({CMD_POLL, 24'h0}, OP_NONE);
                    `CHK(r[7:0], 8'h00)
                end
            end
        end
        prog_rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(prog_enabled, 1'b0)
        `CHK(miso, 1'b0)
        tally_and_finish;
    end
endmodule : tb
